// >>> design/pgio_top.sv
// How it works
// - Enable bit 7 makes signal input an output
// - Enable bit 6 replaces clock output function
// - Bits 5,4 drive interface select pins
// - Bits 3..0 drive TCK, TMS, TDI, TDO
// - Boundary scan masks enable bits 3..0
// - Enable register at 44h, read/write
// - Value register at 45h, read/write
// - Value bit drives its enabled pin
// - Read-only pin level register at 46h
`timescale 1ns/10ps
module pgio_top (
  input  wire logic                           mclk,
  input  wire logic                           rstn,
  // Register port
  input  wire logic [7:0]                     reg_addr,
  input  wire logic [7:0]                     reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [7:0]                     reg_rdata,
  // Boundary scan strap from nonvolatile configuration
  input  wire logic                           boundary_scan_on,
  // Normal functions of each pin (oe low = drive)
  input  wire logic [pgio_pkg::PGIO_NPINS-1:0] func_out,
  input  wire logic [pgio_pkg::PGIO_NPINS-1:0] func_oe_n,
  // Pads
  input  wire logic [pgio_pkg::PGIO_NPINS-1:0] pad_in,
  output logic      [pgio_pkg::PGIO_NPINS-1:0] pad_out,
  output logic      [pgio_pkg::PGIO_NPINS-1:0] pad_oe_n
);
  import pgio_pkg::*;

  logic [7:0] pad_output_enable_q;
  logic [7:0] pad_output_value_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       scan_q;
  logic [7:0] pad_out_q;
  logic [7:0] pad_out_d;
  logic [7:0] pad_oe_n_q;
  logic [7:0] pad_oe_n_d;
  logic [7:0] pad_input_level;
  logic [7:0] effective_en;

  // ==========================================================================
  // Register decode
  wire wr_en  = reg_wr && (reg_addr == PGIO_ADDR_OUT_EN);
  wire wr_val = reg_wr && (reg_addr == PGIO_ADDR_OUT_VAL);

  always_comb begin
    unique case (reg_addr)
      PGIO_ADDR_OUT_EN:  rdata_d = pad_output_enable_q;
      PGIO_ADDR_OUT_VAL: rdata_d = pad_output_value_q;
      PGIO_ADDR_IN_LVL:  rdata_d = pad_input_level;
      default:           rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pad_output_enable_q <= PGIO_OUT_EN_RST;
      pad_output_value_q  <= PGIO_OUT_VAL_RST;
      rdata_q             <= 8'h00;
    end else begin
      if (wr_en) begin
        pad_output_enable_q <= reg_wdata;
      end
      if (wr_val) begin
        pad_output_value_q <= reg_wdata;
      end
      rdata_q <= reg_rd ? rdata_d : 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // ==========================================================================
  // Strap capture, sampled every cycle after release
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scan_q <= 1'b0;
    end else begin
      scan_q <= boundary_scan_on;
    end
  end

  // ==========================================================================
  // Pin level sampling
  pgio_sync #(
    .WIDTH (PGIO_NPINS)
  ) u_sync (
    .mclk     (mclk),
    .rstn     (rstn),
    .async_in (pad_in),
    .sync_out (pad_input_level)
  );

  // ==========================================================================
  // Pad multiplexing
  assign effective_en = pad_output_enable_q & ~(scan_q ? PGIO_SCAN_MASK : 8'h00);

  genvar gi;
  generate
    for (gi = 0; gi < PGIO_NPINS; gi++) begin : g_pin
      assign pad_out_d[gi]  = effective_en[gi] ? pad_output_value_q[gi] : func_out[gi];
      assign pad_oe_n_d[gi] = effective_en[gi] ? 1'b0 : func_oe_n[gi];
    end
  endgenerate

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pad_out_q  <= 8'h00;
      pad_oe_n_q <= 8'hff;
    end else begin
      pad_out_q  <= pad_out_d;
      pad_oe_n_q <= pad_oe_n_d;
    end
  end

  assign pad_out  = pad_out_q;
  assign pad_oe_n = pad_oe_n_q;

  // ==========================================================================
  // Checks
  logic past_valid_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      past_valid_q <= 1'b0;
    end else begin
      past_valid_q <= 1'b1;
    end
  end

  sequence s_write_en;
    reg_wr && reg_addr == PGIO_ADDR_OUT_EN;
  endsequence

  sequence s_write_val;
    reg_wr && reg_addr == PGIO_ADDR_OUT_VAL;
  endsequence

  en_write_a: assert property (@(posedge mclk) disable iff (!rstn)
    s_write_en |=> pad_output_enable_q == $past(reg_wdata))
    else $error("enable register write lost");

  val_write_a: assert property (@(posedge mclk) disable iff (!rstn)
    s_write_val |=> pad_output_value_q == $past(reg_wdata))
    else $error("value register write lost");

  en_readback_a: assert property (@(posedge mclk) disable iff (!rstn)
    reg_rd && reg_addr == PGIO_ADDR_OUT_EN && !reg_wr |=> reg_rdata == pad_output_enable_q)
    else $error("enable readback wrong");

  in_readback_a: assert property (@(posedge mclk) disable iff (!rstn)
    reg_rd && reg_addr == PGIO_ADDR_IN_LVL |=> reg_rdata == $past(pad_input_level))
    else $error("pin level readback wrong");

  signal_input_pin_drive_a: assert property (@(posedge mclk) disable iff (!rstn)
    past_valid_q && $past(pad_output_enable_q[PGIO_BIT_SIGNAL_INPUT_PIN])
      |-> !pad_oe_n[PGIO_BIT_SIGNAL_INPUT_PIN] && pad_out[PGIO_BIT_SIGNAL_INPUT_PIN]
          == $past(pad_output_value_q[PGIO_BIT_SIGNAL_INPUT_PIN]))
    else $error("signal input pin not driven");

  clock_output_pin_drive_a: assert property (@(posedge mclk) disable iff (!rstn)
    past_valid_q && $past(pad_output_enable_q[PGIO_BIT_CLOCK_OUTPUT_PIN])
      |-> pad_out[PGIO_BIT_CLOCK_OUTPUT_PIN] == $past(pad_output_value_q[PGIO_BIT_CLOCK_OUTPUT_PIN]))
    else $error("clock output not replaced");

  ifsel_drive_a: assert property (@(posedge mclk) disable iff (!rstn)
    past_valid_q && $past(pad_output_enable_q[PGIO_BIT_INTERFACE_SELECT_PIN_1])
      |-> !pad_oe_n[PGIO_BIT_INTERFACE_SELECT_PIN_1])
    else $error("interface select pin not driven");

  scan_keep_a: assert property (@(posedge mclk) disable iff (!rstn)
    past_valid_q && $past(scan_q)
      |-> pad_oe_n[3:0] == $past(func_oe_n[3:0]) && pad_out[3:0] == $past(func_out[3:0]))
    else $error("scan pins overridden");

  scan_drive_a: assert property (@(posedge mclk) disable iff (!rstn)
    past_valid_q && !$past(scan_q) && $past(pad_output_enable_q[PGIO_BIT_TDO])
      |-> !pad_oe_n[PGIO_BIT_TDO])
    else $error("test pin not driven");

  normal_func_a: assert property (@(posedge mclk) disable iff (!rstn)
    past_valid_q && $past(pad_output_enable_q) == 8'h00
      |-> pad_out == $past(func_out) && pad_oe_n == $past(func_oe_n))
    else $error("disabled pin not in normal function");

  value_pin_a: assert property (@(posedge mclk) disable iff (!rstn)
    s_write_val ##1 (pad_output_enable_q[PGIO_BIT_TMS] && !scan_q)
      |=> pad_out[PGIO_BIT_TMS] == $past(pad_output_value_q[PGIO_BIT_TMS], 1))
    else $error("value bit not on pin");
endmodule

// >>> shared/pgio_pkg.sv
package pgio_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] PGIO_ADDR_OUT_EN  = 8'h44;
  localparam logic [7:0] PGIO_ADDR_OUT_VAL = 8'h45;
  localparam logic [7:0] PGIO_ADDR_IN_LVL  = 8'h46;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] PGIO_OUT_EN_RST  = 8'h00;
  localparam logic [7:0] PGIO_OUT_VAL_RST = 8'h00;

  // ==========================================================================
  // Pin positions
  localparam int PGIO_NPINS      = 8;
  localparam int PGIO_BIT_SIGNAL_INPUT_PIN  = 7;
  localparam int PGIO_BIT_CLOCK_OUTPUT_PIN = 6;
  localparam int PGIO_BIT_INTERFACE_SELECT_PIN_1 = 5;
  localparam int PGIO_BIT_INTERFACE_SELECT_PIN_0 = 4;
  localparam int PGIO_BIT_TCK    = 3;
  localparam int PGIO_BIT_TMS    = 2;
  localparam int PGIO_BIT_TDI    = 1;
  localparam int PGIO_BIT_TDO    = 0;

  // Scan pins that boundary scan keeps
  localparam logic [7:0] PGIO_SCAN_MASK = 8'h0f;

  // Input synchroniser depth
  localparam int PGIO_SYNC_STAGES = 3;

endpackage

// >>> design/pgio_sync.sv
`timescale 1ns/10ps
module pgio_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import pgio_pkg::*;

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] out_d;

  // ==========================================================================
  // Three stages, output follows when stages two and three agree
  assign out_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & out_q);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q  <= async_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;
endmodule

// >>> tb/pgio_board.sv
`timescale 1ns/10ps
module pgio_board (
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe_n,
  input  wire logic [7:0] ext_lvl,
  input  wire logic [7:0] ext_drv_n,
  output logic      [7:0] pad_in
);
  // ==========================================================
  // Pin resolution: pull-up when nobody drives, x on contention
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad_oe_n[i]) begin
        pad_in[i] = ext_drv_n[i] ? pad_out[i] : 1'bx;
      end else begin
        pad_in[i] = ext_drv_n[i] ? 1'b1 : ext_lvl[i];
      end
    end
  end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import pgio_pkg::*;
  logic       mclk, rstn, reg_wr, reg_rd, scan;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, f_out, f_oe_n;
  logic [7:0] p_in, p_out, p_oe_n, x_lvl, x_drv_n, rv;
  int         fails, samples_checked, cyc;

  pgio_top dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .boundary_scan_on(scan),
    .func_out(f_out), .func_oe_n(f_oe_n), .pad_in(p_in), .pad_out(p_out), .pad_oe_n(p_oe_n));
  pgio_board board (.pad_out(p_out), .pad_oe_n(p_oe_n), .ext_lvl(x_lvl),
    .ext_drv_n(x_drv_n), .pad_in(p_in));

  // ==========================================================
  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      $display("[ERR] timeout exp 0 got 1");
      stop_test;
    end
  end

  // ==========================================================
  // Bus and check helpers
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task pchk(input logic [7:0] en, input logic [7:0] val);
    logic [7:0] m;
    m = en & ~(scan ? PGIO_SCAN_MASK : 8'h00);
    chk("pad_out", (m & val) | (~m & f_out), p_out);
    chk("pad_oe_n", ~m & f_oe_n, p_oe_n);
  endtask
  task stop_test;
    $display("counts: %0d checked, %0d failed", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task t_reset;
    rd(PGIO_ADDR_OUT_EN, rv);  chk("en_rst", PGIO_OUT_EN_RST, rv);
    rd(PGIO_ADDR_OUT_VAL, rv); chk("val_rst", PGIO_OUT_VAL_RST, rv);
    pchk(8'h00, 8'h00);
    rd(8'h50, rv); chk("unmapped", 8'h00, rv);
    $display("test reset done");
  endtask
  task t_regs;
    wr(PGIO_ADDR_OUT_EN, 8'ha5);
    wr(PGIO_ADDR_OUT_VAL, 8'h3c);
    wr(PGIO_ADDR_IN_LVL, 8'h00);
    rd(PGIO_ADDR_OUT_EN, rv);  chk("en_rw", 8'ha5, rv);
    rd(PGIO_ADDR_OUT_VAL, rv); chk("val_rw", 8'h3c, rv);
    $display("test regs done");
  endtask
  task t_pins;
    for (int i = 0; i < 8; i++) begin
      wr(PGIO_ADDR_OUT_EN, 8'h01 << i);
      wr(PGIO_ADDR_OUT_VAL, ~f_out);
      repeat (2) @(posedge mclk);
      #1 pchk(8'h01 << i, ~f_out);
    end
    $display("test pins done");
  endtask
  task t_scan;
    @(posedge mclk);
    scan <= 1'b1;
    wr(PGIO_ADDR_OUT_EN, 8'hff);
    wr(PGIO_ADDR_OUT_VAL, 8'h00);
    repeat (3) @(posedge mclk);
    #1 pchk(8'hff, 8'h00);
    @(posedge mclk);
    scan <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 pchk(8'hff, 8'h00);
    $display("test scan done");
  endtask
  task t_input;
    wr(PGIO_ADDR_OUT_EN, 8'h00);
    f_oe_n <= 8'hff;
    x_lvl  <= 8'h96;
    // Board drives only once the pads have let go
    @(posedge mclk);
    x_drv_n <= 8'h00;
    repeat (8) @(posedge mclk);
    rd(PGIO_ADDR_IN_LVL, rv); chk("in_ext", 8'h96, rv);
    @(posedge mclk);
    x_drv_n <= 8'hff;
    repeat (8) @(posedge mclk);
    rd(PGIO_ADDR_IN_LVL, rv); chk("in_pull", 8'hff, rv);
    wr(PGIO_ADDR_OUT_EN, 8'hff);
    wr(PGIO_ADDR_OUT_VAL, 8'h3c);
    repeat (8) @(posedge mclk);
    rd(PGIO_ADDR_IN_LVL, rv); chk("in_own", 8'h3c, rv);
    $display("test input done");
  endtask
  task t_rerst;
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rd(PGIO_ADDR_OUT_EN, rv);
    chk("en_rerst", PGIO_OUT_EN_RST, rv);
    rd(PGIO_ADDR_OUT_VAL, rv);
    chk("val_rerst", PGIO_OUT_VAL_RST, rv);
    pchk(8'h00, 8'h00);
    $display("test rerst done");
  endtask

  initial begin
    rstn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    scan = 1'b0; f_out = 8'h5a; f_oe_n = 8'hf0; x_lvl = 8'h00; x_drv_n = 8'hff;
    fails = 0; samples_checked = 0; cyc = 0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    t_reset;
    t_regs;
    t_pins;
    t_scan;
    t_input;
    t_rerst;
    stop_test;
  end
endmodule
